// ---- pkg/ett_pkg.sv ----
// Shared constants and types of the eight/sixteen bit timer
package ett_pkg;
  localparam int unsigned IDX_W = 14;
  localparam int unsigned ADDR_LSB = 2;
  localparam int unsigned BYTE_W = 8;
  localparam int unsigned PRE_W = 15;
  localparam int unsigned POST_W = 4;
  localparam int unsigned WIDE_W = 16;
  localparam logic [13:0] IDX_LOW = 14'h0FD2;
  localparam logic [13:0] IDX_HIGH = 14'h0FD3;
  localparam logic [13:0] IDX_CON0 = 14'h0FD4;
  localparam logic [13:0] IDX_CON1 = 14'h0FD5;
  localparam logic [7:0] REG_RESET = 8'h00;
  localparam int unsigned CON0_EN_BIT = 7;
  localparam int unsigned CON0_OUT_BIT = 5;
  localparam int unsigned CON0_WIDE_BIT = 4;
  localparam int unsigned CON0_PS_MSB = 3;
  localparam int unsigned CON0_PS_LSB = 0;
  localparam int unsigned CON1_CS_MSB = 7;
  localparam int unsigned CON1_CS_LSB = 5;
  localparam int unsigned CON1_BYPASS_BIT = 4;
  localparam int unsigned CON1_PRE_MSB = 3;
  localparam int unsigned CON1_PRE_LSB = 0;
  localparam logic [15:0] WIDE_MAX = 16'hFFFF;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  typedef enum logic [2:0] {
    SRC_PIN = 3'h0,
    SRC_PIN_INV = 3'h1,
    SRC_FOSC4 = 3'h2,
    SRC_FAST_OSC = 3'h3,
    SRC_SLOW_OSC = 3'h4,
    SRC_SEC_OSC = 3'h5,
    SRC_MED_OSC = 3'h6,
    SRC_LOGIC_CELL = 3'h7
  } ett_src_t;
endpackage

// ---- pkg/ett_reg_if.sv ----
// Register strobe carrier between the bus slave and the timer core
`timescale 1ns/1ps
interface ett_reg_if;
  logic wr_en;
  logic rd_en;
  logic [13:0] idx;
  logic [7:0] wdata;
  logic [7:0] rdata;
  modport slave (output wr_en, output rd_en, output idx, output wdata, input rdata);
  modport core (input wr_en, input rd_en, input idx, input wdata, output rdata);
endinterface

// ---- src/ett_axil_slave.sv ----
// AXI4-Lite slave producing byte register strobes
`timescale 1ns/1ps
module ett_axil_slave #(
  parameter int unsigned ADDR_W = 16
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  ett_reg_if.slave rif
);
  if (ADDR_W < ett_pkg::IDX_W + ett_pkg::ADDR_LSB) begin : g_chk
    $error("ADDR_W too small for the register indices");
  end
  logic wready_reg;
  logic arready_reg;
  logic bvalid_reg;
  logic rvalid_reg;
  logic [1:0] bresp_reg;
  logic [1:0] rresp_reg;
  logic [31:0] rdata_reg;
  wire wr_go = s_axi_awvalid && s_axi_wvalid && !wready_reg && !bvalid_reg;
  wire rd_go = s_axi_arvalid && !arready_reg && !rvalid_reg && !wr_go && !wready_reg;
  wire wr_hs = wready_reg && s_axi_awvalid && s_axi_wvalid;
  wire rd_hs = arready_reg && s_axi_arvalid;
  wire [ADDR_W-1:0] sel_addr = wready_reg ? s_axi_awaddr : s_axi_araddr;
  wire [13:0] sel_idx = sel_addr[ett_pkg::ADDR_LSB +: ett_pkg::IDX_W];
  wire hit = (sel_idx >= ett_pkg::IDX_LOW) && (sel_idx <= ett_pkg::IDX_CON1)
    && (sel_addr[ett_pkg::ADDR_LSB-1:0] == 2'h0)
    && (sel_addr >> (ett_pkg::IDX_W + ett_pkg::ADDR_LSB) == '0);
  wire [1:0] resp = hit ? ett_pkg::RESP_OKAY : ett_pkg::RESP_SLVERR;
  // Only byte lane 0 carries register data
  assign rif.wr_en = wr_hs && hit && s_axi_wstrb[0];
  assign rif.rd_en = rd_hs && hit;
  assign rif.idx = sel_idx;
  assign rif.wdata = s_axi_wdata[7:0];
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wready_reg <= 1'b0;
      arready_reg <= 1'b0;
      bvalid_reg <= 1'b0;
      rvalid_reg <= 1'b0;
      bresp_reg <= ett_pkg::RESP_OKAY;
      rresp_reg <= ett_pkg::RESP_OKAY;
      rdata_reg <= 32'h0;
    end else begin
      wready_reg <= wr_go;
      arready_reg <= rd_go;
      if (wr_hs) begin
        bvalid_reg <= 1'b1;
        bresp_reg <= resp;
      end else if (s_axi_bready) begin
        bvalid_reg <= 1'b0;
      end
      if (rd_hs) begin
        rvalid_reg <= 1'b1;
        rresp_reg <= resp;
        rdata_reg <= hit ? {24'h0, rif.rdata} : 32'h0;
      end else if (s_axi_rready) begin
        rvalid_reg <= 1'b0;
      end
    end
  end
  assign s_axi_awready = wready_reg;
  assign s_axi_wready = wready_reg;
  assign s_axi_arready = arready_reg;
  assign s_axi_bvalid = bvalid_reg;
  assign s_axi_bresp = bresp_reg;
  assign s_axi_rvalid = rvalid_reg;
  assign s_axi_rresp = rresp_reg;
  assign s_axi_rdata = rdata_reg;
endmodule

// ---- src/ett_timer.sv ----
// Eight/sixteen bit timer with prescaler, postscaler and AXI4-Lite registers
// Function
// - The timer counts only while the enable bit of the first control register is one.
// - The first control register shows the output level on bit 5, and writes to it are ignored.
// - The wide mode bit picks a 16-bit free-running timer, otherwise an 8-bit timer with a period.
// - The postscaler divides timer events by the select field plus one, from 1:1 to 1:16.
// - The clock source select field of the second control register picks the counting clock.
// - With the bypass bit zero the counter input is aligned to the instruction clock, else not.
// - The prescaler divides the selected input by two to the power of its four-bit code.
// - In 8-bit mode the high register is the period, and the low count restarts from zero on reaching it.
// - In 16-bit mode the high register buffers the most significant byte of the count.
// - The low register holds the running count, whole in 8-bit mode and the low byte in 16-bit mode.
// - Source codes map to the pin, the inverted pin, the instruction clock, the oscillators and the logic cell.
// - In 8-bit mode a match with the buffered period clears the count and reloads the buffer.
// - In 16-bit mode reading the low byte latches the high byte, and writing the low byte loads it.
// - The interrupt flag is raised each time the postscaled output toggles.
`timescale 1ns/1ps
module ett_timer #(
  parameter int unsigned ADDR_W = 16
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic instruction_tick,
  input wire logic selected_input_pin,
  input wire logic fast_internal_oscillator,
  input wire logic slow_internal_oscillator,
  input wire logic medium_internal_oscillator,
  input wire logic secondary_oscillator,
  input wire logic first_logic_cell_output,
  output logic postscaled_output,
  output logic timer_interrupt_flag
);
  ett_reg_if rif ();

  // Refuse an address bus too narrow for the register indices
  if (ADDR_W < ett_pkg::IDX_W + ett_pkg::ADDR_LSB) begin : g_addr_chk
    $error("ADDR_W too small for the register indices");
  end

  ett_axil_slave #(
    .ADDR_W(ADDR_W)
  ) u_slave (
    .aclk(aclk),
    .aresetn(aresetn),
    .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb),
    .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr),
    .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready),
    .rif(rif.slave)
  );

  logic [7:0] low_reg;
  logic [7:0] high_reg;
  logic [7:0] cnt_high_reg;
  logic [7:0] buf_reg;
  logic en_reg;
  logic wide_reg;
  logic [3:0] post_sel_reg;
  logic out_reg;
  ett_pkg::ett_src_t cs_reg;
  logic bypass_reg;
  logic [3:0] pre_sel_reg;
  logic [14:0] presc_cnt_reg;
  logic [3:0] post_cnt_reg;
  logic src_prev_reg;
  logic pend_reg;
  logic flag_reg;

  // Register decode
  wire wr_low = rif.wr_en && (rif.idx == ett_pkg::IDX_LOW);
  wire wr_high = rif.wr_en && (rif.idx == ett_pkg::IDX_HIGH);
  wire wr_con0 = rif.wr_en && (rif.idx == ett_pkg::IDX_CON0);
  wire wr_con1 = rif.wr_en && (rif.idx == ett_pkg::IDX_CON1);
  wire rd_low = rif.rd_en && (rif.idx == ett_pkg::IDX_LOW);
  wire [7:0] con0_val = {en_reg, 1'b0, out_reg, wide_reg, post_sel_reg};
  wire [7:0] con1_val = {cs_reg, bypass_reg, pre_sel_reg};
  assign rif.rdata = (rif.idx == ett_pkg::IDX_LOW) ? low_reg :
                     (rif.idx == ett_pkg::IDX_HIGH) ? high_reg :
                     (rif.idx == ett_pkg::IDX_CON0) ? con0_val :
                     (rif.idx == ett_pkg::IDX_CON1) ? con1_val : ett_pkg::REG_RESET;

  // Clock source selection and edge detection
  wire src_raw = (cs_reg == ett_pkg::SRC_PIN) ? selected_input_pin :
                 (cs_reg == ett_pkg::SRC_PIN_INV) ? ~selected_input_pin :
                 (cs_reg == ett_pkg::SRC_FOSC4) ? instruction_tick :
                 (cs_reg == ett_pkg::SRC_FAST_OSC) ? fast_internal_oscillator :
                 (cs_reg == ett_pkg::SRC_SLOW_OSC) ? slow_internal_oscillator :
                 (cs_reg == ett_pkg::SRC_SEC_OSC) ? secondary_oscillator :
                 (cs_reg == ett_pkg::SRC_MED_OSC) ? medium_internal_oscillator :
                 first_logic_cell_output;
  wire src_rise = src_raw && !src_prev_reg;
  // Aligned mode holds a seen edge until the next instruction clock
  wire pend_next = en_reg && !bypass_reg && !instruction_tick && (pend_reg || src_rise);
  wire count_in = en_reg && (bypass_reg ? src_rise :
                  (instruction_tick && (pend_reg || src_rise)));

  // Prescaler: counter and control writes clear it
  wire ctrl_clr = wr_low || wr_con0 || wr_con1;
  wire [15:0] presc_lim16 = (16'h0001 << pre_sel_reg) - 16'h0001;
  wire [14:0] presc_lim = presc_lim16[14:0];
  wire presc_tick = count_in && (presc_cnt_reg == presc_lim);
  wire [14:0] presc_next = ctrl_clr ? 15'h0 :
                           presc_tick ? 15'h0 :
                           count_in ? presc_cnt_reg + 15'h1 : presc_cnt_reg;
  wire adv = presc_tick && !ctrl_clr;

  // Counter
  wire [15:0] wide_cnt = {cnt_high_reg, low_reg};
  wire [15:0] wide_sum = wide_cnt + 16'h0001;
  wire match8 = (low_reg == buf_reg);
  wire wide_top = (wide_cnt == ett_pkg::WIDE_MAX);
  wire tmr_event = adv && (wide_reg ? wide_top : match8);
  wire [7:0] low_step = wide_reg ? wide_sum[7:0] :
                        (match8 ? 8'h00 : low_reg + 8'h01);
  wire [7:0] low_next = wr_low ? rif.wdata : (adv ? low_step : low_reg);
  wire [7:0] cnt_high_next = (wr_low && wide_reg) ? high_reg :
                             (adv && wide_reg) ? wide_sum[15:8] : cnt_high_reg;
  wire [7:0] high_next = wr_high ? rif.wdata :
                         (rd_low && wide_reg) ? cnt_high_reg : high_reg;
  wire [7:0] buf_next = (adv && !wide_reg && match8) ? high_reg : buf_reg;

  // Postscaler and output
  wire post_hit = (post_cnt_reg == post_sel_reg);
  wire [3:0] post_next = ctrl_clr ? 4'h0 :
                         tmr_event ? (post_hit ? 4'h0 : post_cnt_reg + 4'h1) : post_cnt_reg;
  wire out_flip = tmr_event && post_hit;
  wire out_next = out_reg ^ out_flip;
  wire flag_next = out_flip;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      low_reg <= ett_pkg::REG_RESET;
      high_reg <= ett_pkg::REG_RESET;
      cnt_high_reg <= ett_pkg::REG_RESET;
      buf_reg <= ett_pkg::REG_RESET;
      presc_cnt_reg <= 15'h0;
      post_cnt_reg <= 4'h0;
      out_reg <= 1'b0;
      flag_reg <= 1'b0;
      src_prev_reg <= 1'b0;
      pend_reg <= 1'b0;
    end else begin
      low_reg <= low_next;
      high_reg <= high_next;
      cnt_high_reg <= cnt_high_next;
      buf_reg <= buf_next;
      presc_cnt_reg <= presc_next;
      post_cnt_reg <= post_next;
      out_reg <= out_next;
      flag_reg <= flag_next;
      src_prev_reg <= src_raw;
      pend_reg <= pend_next;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      en_reg <= 1'b0;
      wide_reg <= 1'b0;
      post_sel_reg <= 4'h0;
    end else if (wr_con0) begin
      en_reg <= rif.wdata[ett_pkg::CON0_EN_BIT];
      wide_reg <= rif.wdata[ett_pkg::CON0_WIDE_BIT];
      post_sel_reg <= rif.wdata[ett_pkg::CON0_PS_MSB:ett_pkg::CON0_PS_LSB];
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cs_reg <= ett_pkg::SRC_PIN;
      bypass_reg <= 1'b0;
      pre_sel_reg <= 4'h0;
    end else if (wr_con1) begin
      cs_reg <= ett_pkg::ett_src_t'(rif.wdata[ett_pkg::CON1_CS_MSB:ett_pkg::CON1_CS_LSB]);
      bypass_reg <= rif.wdata[ett_pkg::CON1_BYPASS_BIT];
      pre_sel_reg <= rif.wdata[ett_pkg::CON1_PRE_MSB:ett_pkg::CON1_PRE_LSB];
    end
  end

  assign postscaled_output = out_reg;
  assign timer_interrupt_flag = flag_reg;

  // Independent tallies used only by the checks below
  logic [15:0] chk_edges_reg;
  logic [4:0] chk_events_reg;
  wire [15:0] chk_ratio = 16'h0001 << pre_sel_reg;
  always_ff @(posedge aclk) begin
    if (!aresetn || ctrl_clr || presc_tick) begin
      chk_edges_reg <= 16'h0000;
    end else if (count_in) begin
      chk_edges_reg <= chk_edges_reg + 16'h0001;
    end
  end
  always_ff @(posedge aclk) begin
    if (!aresetn || ctrl_clr || out_flip) begin
      chk_events_reg <= 5'h00;
    end else if (tmr_event) begin
      chk_events_reg <= chk_events_reg + 5'h01;
    end
  end

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  a_disabled_hold: assert property (!en_reg && !rif.wr_en |=> $stable(low_reg) && $stable(presc_cnt_reg))
    else $error("count moved while disabled");
  a_hold_resume: assert property (!en_reg && !rif.wr_en |=> $stable(post_cnt_reg) && $stable(cnt_high_reg))
    else $error("postscaler or high count moved while disabled");
  a_out_readonly: assert property (wr_con0 |=> $stable(out_reg))
    else $error("output bit changed by a control write");
  a_wide_roll: assert property (adv && wide_reg && wide_top |=> {cnt_high_reg, low_reg} == 16'h0000)
    else $error("16-bit count did not roll over to zero");
  a_wide_carry: assert property (adv && wide_reg && low_reg == 8'hFF && !wide_top
    |=> cnt_high_reg == $past(cnt_high_reg) + 8'h01)
    else $error("high byte missed the carry");
  a_post_bound: assert property (post_cnt_reg <= post_sel_reg)
    else $error("postscaler count beyond its ratio");
  a_post_ratio: assert property (tmr_event && post_sel_reg == 4'h0 |=> $changed(out_reg))
    else $error("1:1 postscaler did not toggle on an event");
  a_src_inv: assert property (cs_reg == ett_pkg::SRC_PIN_INV |-> src_raw == !selected_input_pin)
    else $error("inverted pin source wrong");
  a_src_fosc: assert property (cs_reg == ett_pkg::SRC_FOSC4 |-> src_raw == instruction_tick)
    else $error("instruction clock source wrong");
  a_sync_align: assert property (!bypass_reg && count_in |-> instruction_tick)
    else $error("aligned input counted off the instruction clock");
  a_presc_div: assert property (count_in |-> presc_tick == (chk_edges_reg + 16'h0001 == chk_ratio))
    else $error("prescaler release off its ratio");
  a_presc_zero: assert property (pre_sel_reg == 4'h0 |-> presc_tick == count_in)
    else $error("1:1 prescaler dropped an input");
  a_period_restart: assert property (adv && !wide_reg && match8 |=> low_reg == 8'h00
    && buf_reg == $past(high_reg))
    else $error("period match did not restart and reload");
  a_count_step: assert property (adv && !wide_reg && !match8 |=> low_reg == $past(low_reg) + 8'h01)
    else $error("8-bit count did not step");
  a_buf_hold: assert property (!(adv && !wide_reg && match8) |=> $stable(buf_reg))
    else $error("period buffer changed without a match");
  a_high_latch: assert property (rd_low && wide_reg && !wr_high |=> high_reg == $past(cnt_high_reg))
    else $error("reading the low byte did not latch the high byte");
  a_high_load: assert property (wr_low && wide_reg |=> cnt_high_reg == $past(high_reg))
    else $error("writing the low byte did not load the high byte");
  a_flag_toggle: assert property (flag_reg == $changed(out_reg))
    else $error("flag and output toggle disagree");
  // Ratio, gating, register write, alignment, counting, source and flag checks
  a_post_count: assert property (tmr_event |-> out_flip == (chk_events_reg == {1'b0, post_sel_reg}))
    else $error("postscaler toggled off its ratio");
  a_count_gate: assert property (count_in |-> en_reg)
    else $error("input counted while disabled");
  a_enable_write: assert property (wr_con0 |=> en_reg == $past(rif.wdata[ett_pkg::CON0_EN_BIT]))
    else $error("enable bit not taken from the write");
  a_ctrl_clear: assert property (ctrl_clr |=> presc_cnt_reg == 15'h0 && post_cnt_reg == 4'h0)
    else $error("scaler counts not cleared by a write");
  a_bypass_now: assert property (en_reg && bypass_reg && src_rise |-> count_in)
    else $error("unaligned edge not counted at once");
  a_sync_wait: assert property (en_reg && !bypass_reg && pend_reg && instruction_tick |-> count_in)
    else $error("waiting edge not counted on the instruction clock");
  a_wide_step: assert property (adv && wide_reg |=> {cnt_high_reg, low_reg} == $past(wide_cnt) + 16'h0001)
    else $error("16-bit count did not step");
  a_narrow_hold: assert property (!wide_reg |=> $stable(cnt_high_reg))
    else $error("high count moved in 8-bit mode");
  a_low_write: assert property (wr_low |=> low_reg == $past(rif.wdata))
    else $error("low register write lost");
  a_high_write: assert property (wr_high |=> high_reg == $past(rif.wdata))
    else $error("period register write lost");
  a_src_pin: assert property (cs_reg == ett_pkg::SRC_PIN |-> src_raw == selected_input_pin)
    else $error("plain pin source wrong");
  a_flag_cause: assert property (flag_reg |-> $past(tmr_event))
    else $error("flag raised without a timer event");

  c_period_match: cover property (adv && !wide_reg && match8 && high_reg != 8'h00);
  c_wide_roll: cover property (adv && wide_reg && wide_top);
  c_flag_post: cover property (flag_reg && post_sel_reg != 4'h0);
  c_sync_wait: cover property (pend_reg && !bypass_reg ##1 count_in);
  c_presc_long: cover property (presc_tick && pre_sel_reg == 4'h2);
endmodule

// ---- tb/eight_sixteen_bit_timer_test.sv ----
// Self-checking bench for the eight/sixteen bit timer over its register bus and clock sources
`timescale 1ns/1ps
module eight_sixteen_bit_timer_test;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [15:0] awaddr = 16'h0000;
  logic [15:0] araddr = 16'h0000;
  logic [31:0] wdata = 32'h00000000;
  logic [3:0] wstrb = 4'h0;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid, pout, pflag;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata;
  logic [7:0] lv = 8'h00;
  logic [7:0] m_low = 8'h00, m_high = 8'h00, m_buf = 8'h00, m_hi = 8'h00, con0 = 8'h00, con1 = 8'h00;
  logic m_out = 1'b0;
  int m_pre = 0, m_post = 0, n_tog = 0, n_flag = 0, n_errors = 0, checks_done = 0, p, seed;
  logic [33:0] rq[$];
  logic [1:0] bq[$];

  ett_timer dut_u (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .instruction_tick(lv[2]), .selected_input_pin(lv[0]), .fast_internal_oscillator(lv[3]),
    .slow_internal_oscillator(lv[4]), .medium_internal_oscillator(lv[6]), .secondary_oscillator(lv[5]),
    .first_logic_cell_output(lv[7]), .postscaled_output(pout), .timer_interrupt_flag(pflag));

  initial begin
    forever #12.5 aclk = ~aclk;
  end

  task automatic chk(input string what, input logic [33:0] e, input logic [33:0] s);
    checks_done++;
    if (s !== e) begin
      n_errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, e, s);
    end
  endtask

  task automatic wrap_up();
    chk("unanswered requests", 34'h0, 34'(rq.size() + bq.size()));
    $display("checks %0d errors %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  // Result watcher: every answer takes the oldest note off its queue
  always @(posedge aclk) begin
    if (rvalid === 1'b1 && rready === 1'b1) begin
      if (rq.size() > 0) chk("read data and response", rq.pop_front(), {rresp, rdata});
      else chk("unexpected read answer", 34'h0, 34'h1);
    end
    if (bvalid === 1'b1 && bready === 1'b1) begin
      if (bq.size() > 0) chk("write response", {32'h0, bq.pop_front()}, {32'h0, bresp});
      else chk("unexpected write answer", 34'h0, 34'h1);
    end
    if (pflag === 1'b1) n_flag++;
  end

  // One counter step of the reference model
  task automatic adv();
    logic [15:0] c16;
    logic ev;
    ev = 1'b0;
    if (con0[4]) begin
      c16 = {m_hi, m_low};
      ev = (c16 == ett_pkg::WIDE_MAX);
      c16 = c16 + 16'h0001;
      {m_hi, m_low} = c16;
    end else if (m_low == m_buf) begin
      m_low = 8'h00;
      m_buf = m_high;
      ev = 1'b1;
    end else m_low = m_low + 8'h01;
    if (ev) begin
      if (m_post == int'(con0[3:0])) begin
        m_post = 0;
        m_out = ~m_out;
        n_tog++;
      end else m_post++;
    end
  endtask

  task automatic edge_m();
    if (con0[7]) begin
      m_pre++;
      if (m_pre == (1 << con1[3:0])) begin
        m_pre = 0;
        adv();
      end
    end
  endtask

  task automatic wr(input logic [13:0] idx, input logic [7:0] d, input logic [3:0] st, input logic [1:0] er);
    bq.push_back(er);
    awaddr <= {idx, 2'b00};
    wdata <= {24'($urandom), d};
    wstrb <= st;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do @(posedge aclk); while (awready !== 1'b1);
    chk("wready with awready", 34'h1, {33'h0, wready});
    awvalid <= 1'b0;
    wvalid <= 1'b0;
    do @(posedge aclk); while (bvalid !== 1'b1);
    bready <= 1'b0;
    @(posedge aclk);
    if (er == ett_pkg::RESP_OKAY && st[0]) begin
      if (idx == ett_pkg::IDX_HIGH) m_high = d;
      else begin
        m_pre = 0;
        m_post = 0;
      end
      if (idx == ett_pkg::IDX_LOW) m_low = d;
      if (idx == ett_pkg::IDX_LOW && con0[4]) m_hi = m_high;
      if (idx == ett_pkg::IDX_CON0) con0 = d & 8'h9F;
      if (idx == ett_pkg::IDX_CON1) con1 = d;
    end
  endtask

  task automatic rd(input logic [13:0] idx);
    logic [33:0] e;
    e = {ett_pkg::RESP_SLVERR, 32'h0};
    if (idx == ett_pkg::IDX_LOW) e = {ett_pkg::RESP_OKAY, 24'h0, m_low};
    if (idx == ett_pkg::IDX_HIGH) e = {ett_pkg::RESP_OKAY, 24'h0, m_high};
    if (idx == ett_pkg::IDX_CON0) e = {ett_pkg::RESP_OKAY, 24'h0, con0[7], 1'b0, m_out, con0[4:0]};
    if (idx == ett_pkg::IDX_CON1) e = {ett_pkg::RESP_OKAY, 24'h0, con1};
    rq.push_back(e);
    if (idx == ett_pkg::IDX_LOW && con0[4]) m_high = m_hi;
    araddr <= {idx, 2'b00};
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(posedge aclk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    do @(posedge aclk); while (rvalid !== 1'b1);
    rready <= 1'b0;
    @(posedge aclk);
  endtask

  // One rising edge on source c, with noise on the unselected oscillators and logic cell output
  task automatic pulse(input int c);
    logic [7:0] idle, act;
    idle = (con1[7:5] == 3'h1) ? 8'h01 : 8'h00;
    act = idle ^ (8'h01 << ((c == 1) ? 0 : c));
    lv <= act | (8'($urandom) & 8'hF8 & ~(8'h01 << c));
    @(posedge aclk);
    lv <= idle | (8'($urandom) & 8'hF8 & ~(8'h01 << c));
    repeat (2) @(posedge aclk);
    lv <= idle;
    repeat (3) @(posedge aclk);
  endtask

  initial begin
    repeat (20000) @(posedge aclk);
    n_errors++;
    $display("CHECK FAILED watchdog expected finish seen timeout");
    wrap_up();
  end

  initial begin
    seed = $urandom(48731);
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    for (int i = 0; i < 4; i++) rd(ett_pkg::IDX_LOW + 14'(i));
    rd(14'h0FD6);
    wr(14'h0FD6, 8'h5A, 4'h1, ett_pkg::RESP_SLVERR);
    wr(ett_pkg::IDX_LOW, 8'h5A, 4'h0, ett_pkg::RESP_OKAY);
    rd(ett_pkg::IDX_LOW);
    wr(ett_pkg::IDX_CON0, 8'h3F, 4'h1, ett_pkg::RESP_OKAY);
    rd(ett_pkg::IDX_CON0);
    p = 2 + ($urandom % 4);
    wr(ett_pkg::IDX_HIGH, 8'(p), 4'h1, ett_pkg::RESP_OKAY);
    wr(ett_pkg::IDX_CON1, 8'h10, 4'h1, ett_pkg::RESP_OKAY);
    wr(ett_pkg::IDX_CON0, 8'h81, 4'h1, ett_pkg::RESP_OKAY);
    for (int i = 0; i < 3 * (p + 1) + 2; i++) begin
      pulse(0);
      edge_m();
      rd(ett_pkg::IDX_LOW);
    end
    chk("flag pulses", 34'(n_tog), 34'(n_flag));
    chk("postscaled output", {33'h0, m_out}, {33'h0, pout});
    rd(ett_pkg::IDX_CON0);
    wr(ett_pkg::IDX_CON0, 8'h01, 4'h1, ett_pkg::RESP_OKAY);
    repeat (3) pulse(0);
    rd(ett_pkg::IDX_LOW);
    wr(ett_pkg::IDX_CON0, 8'h90, 4'h1, ett_pkg::RESP_OKAY);
    wr(ett_pkg::IDX_HIGH, 8'hFF, 4'h1, ett_pkg::RESP_OKAY);
    wr(ett_pkg::IDX_LOW, 8'hFD, 4'h1, ett_pkg::RESP_OKAY);
    wr(ett_pkg::IDX_CON1, 8'h12, 4'h1, ett_pkg::RESP_OKAY);
    repeat (9) begin
      pulse(0);
      edge_m();
    end
    rd(ett_pkg::IDX_LOW);
    rd(ett_pkg::IDX_HIGH);
    wr(ett_pkg::IDX_CON1, 8'h10, 4'h1, ett_pkg::RESP_OKAY);
    pulse(0);
    edge_m();
    rd(ett_pkg::IDX_LOW);
    rd(ett_pkg::IDX_HIGH);
    chk("flag pulses", 34'(n_tog), 34'(n_flag));
    chk("postscaled output", {33'h0, m_out}, {33'h0, pout});
    wr(ett_pkg::IDX_CON1, 8'h00, 4'h1, ett_pkg::RESP_OKAY);
    pulse(0);
    rd(ett_pkg::IDX_LOW);
    pulse(2);
    edge_m();
    rd(ett_pkg::IDX_LOW);
    for (int c = 0; c < 8; c++) begin
      wr(ett_pkg::IDX_CON0, 8'h10, 4'h1, ett_pkg::RESP_OKAY);
      lv <= (c == 1) ? 8'h01 : 8'h00;
      wr(ett_pkg::IDX_CON1, {3'(c), 5'h10}, 4'h1, ett_pkg::RESP_OKAY);
      wr(ett_pkg::IDX_CON0, 8'h90, 4'h1, ett_pkg::RESP_OKAY);
      pulse(c);
      edge_m();
      rd(ett_pkg::IDX_LOW);
    end
    wrap_up();
  end
endmodule
